// ### verilog/dmx_consts.vh
`ifndef DMX_CONSTS_VH
`define DMX_CONSTS_VH

// ****************************************************************
// Register map, one byte per register
// ****************************************************************
`define DMX_REG_BASE 8'h7C
`define DMX_REG_COUNT 16
`define DMX_REG_LAST 8'h8B
`define DMX_ADDR_LEFT_SOURCE_SELECT 8'h7C
`define DMX_ADDR_LEFT_FILT1_LEFT_GAIN 8'h7D
`define DMX_ADDR_LEFT_FILT1_RIGHT_GAIN 8'h7E
`define DMX_ADDR_LEFT_FILT2_LEFT_GAIN 8'h7F
`define DMX_ADDR_LEFT_FILT2_RIGHT_GAIN 8'h80
`define DMX_ADDR_LEFT_TONE_GAIN 8'h81
`define DMX_ADDR_LEFT_RX1_LEFT_GAIN 8'h82
`define DMX_ADDR_LEFT_RX1_RIGHT_GAIN 8'h83
`define DMX_ADDR_RIGHT_SOURCE_SELECT 8'h84
`define DMX_ADDR_RIGHT_FILT1_LEFT_GAIN 8'h85
`define DMX_ADDR_RIGHT_FILT1_RIGHT_GAIN 8'h86
`define DMX_ADDR_RIGHT_FILT2_LEFT_GAIN 8'h87
`define DMX_ADDR_RIGHT_FILT2_RIGHT_GAIN 8'h88
`define DMX_ADDR_RIGHT_TONE_GAIN 8'h89
`define DMX_ADDR_RIGHT_RX1_LEFT_GAIN 8'h8A
`define DMX_ADDR_RIGHT_RX1_RIGHT_GAIN 8'h8B

// ****************************************************************
// Register indices relative to the base
// ****************************************************************
`define DMX_IDX_LEFT_MASK 4'h0
`define DMX_IDX_RIGHT_MASK 4'h8

// ****************************************************************
// Field layout and reset values
// ****************************************************************
`define DMX_MASK_READ 8'h7F
`define DMX_GAIN_READ 8'h1F
`define DMX_LEFT_MASK_RESET 8'h04
`define DMX_RIGHT_MASK_RESET 8'h08
`define DMX_GAIN_RESET 8'h1C
`define DMX_UNMAPPED_READ 8'h00

// ****************************************************************
// Datapath
// ****************************************************************
`define DMX_SOURCES 7
`define DMX_SAMPLE_W 24
`define DMX_COEF_W 16
`define DMX_COEF_FRAC 14
`define DMX_FIFO_DEPTH 4
`define DMX_FIFO_AW 2

`endif

// ### verilog/dmx_fifo.v
`timescale 1ns/1ps

module dmx_fifo #(
	parameter WIDTH = 48,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	input wire clk,
	input wire rst_n,
	input wire in_valid,
	output reg in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_reg;
	reg [AW-1:0] rd_ptr_reg;
	reg [AW:0] count_reg;
	wire push;
	wire pop;
	wire [AW:0] count_next;

	assign out_valid = (count_reg != {(AW+1){1'b0}});
	assign out_data = mem_reg[rd_ptr_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

	// ****************************************************************
	// Pointers and fill level
	// ****************************************************************
	// Ready is held in a flop so the filling side never sees a
	// combinational path through the drain side.
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
			in_ready <= 1'b1;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
			count_reg <= count_next;
			in_ready <= (count_next != DEPTH);
		end
	end

	always @(posedge clk)
	begin
		if (push)
			mem_reg[wr_ptr_reg] <= in_data;
	end
endmodule // dmx_fifo

// ### verilog/dmx_mixer.v
// Function
// - 5-bit gain code, 1.5 dB steps
// - Left tone gain, resets unity
// - Left rx-left gain, resets unity
// - Left rx-right gain, resets unity
// - Right output uses 7-bit mask
// - Mask bit order: filters, tone, rx
// - Set bit includes source, clear excludes
// - Routing bit 7 reserved
// - Right mask resets to 0x8
// - Right filt1-left gain, resets unity
// - Right filt1-right gain, resets unity
// - Right filt2-left gain, resets unity
// - Right filt2-right gain, resets unity
// - Left mask resets to 0x4
// - Left filter path gains, same encoding
`timescale 1ns/1ps
`include "dmx_consts.vh"

module dmx_mixer (
	input wire clk,
	input wire rst_n,
	input wire [7:0] reg_addr,
	input wire reg_wr_en,
	input wire [7:0] reg_wdata,
	input wire reg_rd_en,
	output reg [7:0] reg_rdata,
	input wire sample_valid,
	output wire sample_ready,
	input wire [23:0] input_filter_one_left,
	input wire [23:0] input_filter_one_right,
	input wire [23:0] input_filter_two_left,
	input wire [23:0] input_filter_two_right,
	input wire [23:0] tone_source,
	input wire [23:0] serial_in_one_left,
	input wire [23:0] serial_in_one_right,
	output reg out_valid,
	input wire out_ready,
	output reg [23:0] serial_out_two_left,
	output reg [23:0] serial_out_two_right
);
	localparam SW = `DMX_SAMPLE_W;
	localparam NS = `DMX_SOURCES;

	// Sixteen byte registers; index 0 and 8 are routing masks, the rest
	// are gains laid out so that index base+1+n scales source bit n.
	reg [7:0] cfg_reg [0:`DMX_REG_COUNT-1];
	wire [7:0] idx_full;
	wire [3:0] idx;
	wire hit;
	wire [6:0] left_out_source_mask;
	wire [4:0] left_out_f1_left_gain_code;
	wire [4:0] left_out_f1_right_gain_code;
	wire [4:0] left_out_f2_left_gain_code;
	wire [4:0] left_out_f2_right_gain_code;
	wire [4:0] left_out_tone_gain_code;
	wire [4:0] left_out_rx_left_gain_code;
	wire [4:0] left_out_rx_right_gain_code;
	wire [6:0] right_out_source_mask;
	wire [4:0] right_out_f1_left_gain_code;
	wire [4:0] right_out_f1_right_gain_code;
	wire [4:0] right_out_f2_left_gain_code;
	wire [4:0] right_out_f2_right_gain_code;
	wire [4:0] right_out_tone_gain_code;
	wire [4:0] right_out_rx_left_gain_code;
	wire [4:0] right_out_rx_right_gain_code;
	wire [SW*NS-1:0] samples;
	wire [NS*5-1:0] left_gains;
	wire [NS*5-1:0] right_gains;
	wire [SW-1:0] left_mix;
	wire [SW-1:0] right_mix;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [2*SW-1:0] fifo_out_data;
	wire fifo_pop;
	integer i;

	// ****************************************************************
	// Register address decode
	// ****************************************************************
	// Only the low four bits of the offset index the file; the range test
	// keeps addresses outside the window from aliasing onto it.
	assign idx_full = reg_addr - `DMX_REG_BASE;
	assign idx = idx_full[3:0];
	assign hit = (reg_addr >= `DMX_REG_BASE) && (reg_addr <= `DMX_REG_LAST);

	// ****************************************************************
	// Gain code to linear coefficient, unsigned with 14 fraction bits
	// ****************************************************************
	// Each entry is the code's gain as a linear factor, rounded to the
	// nearest step of 2^-14; a lookup avoids any run-time power function.
	function [15:0] gain_coef;
		input [4:0] code;
		begin
			case (code)
				5'h00: gain_coef = 16'h0082;
				5'h01: gain_coef = 16'h009B;
				5'h02: gain_coef = 16'h00B8;
				5'h03: gain_coef = 16'h00DA;
				5'h04: gain_coef = 16'h0104;
				5'h05: gain_coef = 16'h0135;
				5'h06: gain_coef = 16'h016F;
				5'h07: gain_coef = 16'h01B4;
				5'h08: gain_coef = 16'h0206;
				5'h09: gain_coef = 16'h0268;
				5'h0A: gain_coef = 16'h02DC;
				5'h0B: gain_coef = 16'h0366;
				5'h0C: gain_coef = 16'h040A;
				5'h0D: gain_coef = 16'h04CD;
				5'h0E: gain_coef = 16'h05B4;
				5'h0F: gain_coef = 16'h06C7;
				5'h10: gain_coef = 16'h080F;
				5'h11: gain_coef = 16'h0993;
				5'h12: gain_coef = 16'h0B62;
				5'h13: gain_coef = 16'h0D87;
				5'h14: gain_coef = 16'h1013;
				5'h15: gain_coef = 16'h131B;
				5'h16: gain_coef = 16'h16B5;
				5'h17: gain_coef = 16'h1AFD;
				5'h18: gain_coef = 16'h2013;
				5'h19: gain_coef = 16'h261F;
				5'h1A: gain_coef = 16'h2D4F;
				5'h1B: gain_coef = 16'h35D9;
				5'h1C: gain_coef = 16'h4000;
				5'h1D: gain_coef = 16'h4C10;
				5'h1E: gain_coef = 16'h5A67;
				default: gain_coef = 16'h6B72;
			endcase
		end
	endfunction

	// Clipping to full scale rather than wrapping keeps an overdriven mix
	// from turning a loud peak into a full-scale jump of opposite sign.
	function [23:0] saturate;
		input signed [44:0] value;
		begin
			if (value > 45'sh7FFFFF)
				saturate = 24'h7FFFFF;
			else if (value < -45'sh800000)
				saturate = 24'h800000;
			else
				saturate = value[23:0];
		end
	endfunction

	// ****************************************************************
	// One output mix: gain each selected source, sum, saturate
	// ****************************************************************
	// The accumulator carries enough headroom for seven sources at the
	// largest gain, so clipping happens once at the end, not per term.
	function [23:0] mix;
		input [6:0] mask;
		input [34:0] gains;
		input [167:0] smp;
		reg signed [40:0] prod;
		reg signed [44:0] acc;
		reg signed [23:0] s;
		reg [4:0] g;
		integer k;
		begin
			acc = 45'sd0;
			for (k = 0; k < 7; k = k + 1)
			begin
				s = smp[k*24 +: 24];
				g = gains[k*5 +: 5];
				prod = s * $signed({1'b0, gain_coef(g)});
				if (mask[k])
					acc = acc + {{4{prod[40]}}, prod};
			end
			acc = acc >>> `DMX_COEF_FRAC;
			mix = saturate(acc);
		end
	endfunction

	function is_mask_index;
		input [3:0] index;
		begin
			is_mask_index = (index == `DMX_IDX_LEFT_MASK) || (index == `DMX_IDX_RIGHT_MASK);
		end
	endfunction

	function [7:0] read_mask;
		input [3:0] index;
		begin
			if (is_mask_index(index))
				read_mask = `DMX_MASK_READ;
			else
				read_mask = `DMX_GAIN_READ;
		end
	endfunction

	function [7:0] reset_value;
		input [3:0] index;
		begin
			if (index == `DMX_IDX_LEFT_MASK)
				reset_value = `DMX_LEFT_MASK_RESET;
			else if (index == `DMX_IDX_RIGHT_MASK)
				reset_value = `DMX_RIGHT_MASK_RESET;
			else
				reset_value = `DMX_GAIN_RESET;
		end
	endfunction

	// ****************************************************************
	// Register file
	// ****************************************************************
	// A read in the same cycle as a write to that register returns the
	// old byte; the new one is seen from the next read on.
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (i = 0; i < `DMX_REG_COUNT; i = i + 1)
				cfg_reg[i] <= reset_value(i[3:0]);
			reg_rdata <= 8'h00;
		end
		else
		begin
			if (reg_wr_en && hit)
				cfg_reg[idx] <= reg_wdata & read_mask(idx);
			if (reg_rd_en)
				reg_rdata <= hit ? cfg_reg[idx] : `DMX_UNMAPPED_READ;
		end
	end

	// ****************************************************************
	// Configuration fields
	// ****************************************************************
	// The tone and receive gains of the right output sit just past its
	// filter gains, so both outputs can mix all seven sources.
	assign left_out_source_mask = cfg_reg[`DMX_IDX_LEFT_MASK][6:0];
	assign left_out_f1_left_gain_code = cfg_reg[1][4:0];
	assign left_out_f1_right_gain_code = cfg_reg[2][4:0];
	assign left_out_f2_left_gain_code = cfg_reg[3][4:0];
	assign left_out_f2_right_gain_code = cfg_reg[4][4:0];
	assign left_out_tone_gain_code = cfg_reg[5][4:0];
	assign left_out_rx_left_gain_code = cfg_reg[6][4:0];
	assign left_out_rx_right_gain_code = cfg_reg[7][4:0];
	assign right_out_source_mask = cfg_reg[`DMX_IDX_RIGHT_MASK][6:0];
	assign right_out_f1_left_gain_code = cfg_reg[9][4:0];
	assign right_out_f1_right_gain_code = cfg_reg[10][4:0];
	assign right_out_f2_left_gain_code = cfg_reg[11][4:0];
	assign right_out_f2_right_gain_code = cfg_reg[12][4:0];
	assign right_out_tone_gain_code = cfg_reg[13][4:0];
	assign right_out_rx_left_gain_code = cfg_reg[14][4:0];
	assign right_out_rx_right_gain_code = cfg_reg[15][4:0];

	// ****************************************************************
	// Mixing datapath
	// ****************************************************************
	assign samples = {serial_in_one_right, serial_in_one_left, tone_source,
		input_filter_two_right, input_filter_two_left,
		input_filter_one_right, input_filter_one_left};
	assign left_gains = {left_out_rx_right_gain_code, left_out_rx_left_gain_code,
		left_out_tone_gain_code, left_out_f2_right_gain_code, left_out_f2_left_gain_code,
		left_out_f1_right_gain_code, left_out_f1_left_gain_code};
	assign right_gains = {right_out_rx_right_gain_code, right_out_rx_left_gain_code,
		right_out_tone_gain_code, right_out_f2_right_gain_code, right_out_f2_left_gain_code,
		right_out_f1_right_gain_code, right_out_f1_left_gain_code};
	assign left_mix = mix(left_out_source_mask, left_gains, samples);
	assign right_mix = mix(right_out_source_mask, right_gains, samples);
	assign sample_ready = fifo_in_ready;

	// Mixed pairs queue here so a stalled serial output does not hold
	// off the source until four are waiting; beyond that the source must hold.
	dmx_fifo #(
		.WIDTH(2 * SW),
		.DEPTH(`DMX_FIFO_DEPTH),
		.AW(`DMX_FIFO_AW)
	) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(sample_valid),
		.in_ready(fifo_in_ready),
		.in_data({left_mix, right_mix}),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data)
	);

	// ****************************************************************
	// Registered output stage
	// ****************************************************************
	assign fifo_pop = !out_valid || out_ready;

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			out_valid <= 1'b0;
			serial_out_two_left <= 24'h000000;
			serial_out_two_right <= 24'h000000;
		end
		else if (fifo_pop)
		begin
			out_valid <= fifo_out_valid;
			if (fifo_out_valid)
			begin
				serial_out_two_left <= fifo_out_data[2*SW-1:SW];
				serial_out_two_right <= fifo_out_data[SW-1:0];
			end
		end
	end
endmodule // dmx_mixer

// ### testbench/dmx_mixer_monitor.sv
`timescale 1ns/1ps
// ****
// Port checker of the mixer
// ****
module dmx_mixer_monitor (
	input wire clk,
	input wire rst_n,
	input wire [7:0] reg_addr,
	input wire reg_wr_en,
	input wire [7:0] reg_wdata,
	input wire reg_rd_en,
	input wire [7:0] reg_rdata,
	input wire sample_valid,
	input wire sample_ready,
	input wire [23:0] input_filter_one_left,
	input wire [23:0] input_filter_one_right,
	input wire [23:0] input_filter_two_left,
	input wire [23:0] input_filter_two_right,
	input wire [23:0] tone_source,
	input wire [23:0] serial_in_one_left,
	input wire [23:0] serial_in_one_right,
	input wire out_valid,
	input wire out_ready,
	input wire [23:0] serial_out_two_left,
	input wire [23:0] serial_out_two_right
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence take_s; sample_valid && sample_ready; endsequence
	// An empty output stage one cycle after a take means the FIFO was empty too.
	sequence idle_take_s; !out_valid && sample_valid && sample_ready ##1 !out_valid; endsequence
	mask_read_a: assert property (reg_rd_en && (reg_addr == 8'h7C || reg_addr == 8'h84)
		|=> !reg_rdata[7]) else $error("mask bit 7 reads set");
	gain_read_a: assert property (reg_rd_en && reg_addr > 8'h7C && reg_addr <= 8'h8B
		&& reg_addr != 8'h84 |=> reg_rdata[7:5] == 3'h0) else $error("gain high bits set");
	unmapped_read_a: assert property (reg_rd_en && (reg_addr < 8'h7C || reg_addr > 8'h8B)
		|=> reg_rdata == 8'h00) else $error("unmapped read not zero");
	rdata_hold_a: assert property (!reg_rd_en |=> $stable(reg_rdata)) else $error("read data moved");
	pair_hold_a: assert property (out_valid && !out_ready |=> out_valid
		&& $stable(serial_out_two_left) && $stable(serial_out_two_right)) else $error("pair moved");
	out_drop_a: assert property ($fell(out_valid) |-> $past(out_ready)) else $error("pair lost");
	out_latency_a: assert property (idle_take_s |=> out_valid) else $error("output late");
	out_rise_a: assert property ($rose(out_valid) |-> $past(sample_valid && sample_ready, 2))
		else $error("output without take");
	ready_fall_a: assert property ($fell(sample_ready) |-> $past(sample_valid && sample_ready))
		else $error("ready fell without take");
	take_c: cover property (take_s);
endmodule // dmx_mixer_monitor

bind dmx_mixer dmx_mixer_monitor mon (.*);

// ### testbench/dmx_sink.sv
`timescale 1ns/1ps
// ****
// Output sink: prompt, random stalls, or held off
// ****
module dmx_sink (
	input wire clk,
	input wire rst_n,
	input wire [1:0] mode,
	output reg out_ready
);
	always @(negedge clk or negedge rst_n)
	begin
		if (!rst_n)
			out_ready <= 1'b0;
		else
			out_ready <= mode == 2'h0 || (mode == 2'h1 && $urandom % 3 == 0);
	end
endmodule // dmx_sink

// ### testbench/dmx_mixer_tb.sv
`timescale 1ns/1ps
module dmx_mixer_tb;
	logic clk = 0, rst_n = 0, reg_wr_en = 0, reg_rd_en = 0, sample_valid = 0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
	logic [23:0] src [7] = '{default: 24'h0};
	logic [1:0] mode = 2'h0;
	wire [7:0] reg_rdata;
	wire sample_ready, out_valid, out_ready;
	wire [23:0] lo, ro;
	logic [7:0] md [16];
	logic [47:0] exq [$];
	int err_total = 0, total_checks = 0;
	dmx_mixer dut (.clk, .rst_n, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en, .reg_rdata,
		.sample_valid, .sample_ready, .input_filter_one_left(src[0]),
		.input_filter_one_right(src[1]), .input_filter_two_left(src[2]),
		.input_filter_two_right(src[3]), .tone_source(src[4]), .serial_in_one_left(src[5]),
		.serial_in_one_right(src[6]), .out_valid, .out_ready, .serial_out_two_left(lo),
		.serial_out_two_right(ro));
	dmx_sink sink (.clk, .rst_n, .mode, .out_ready);
	initial forever #5 clk = ~clk;
	// ****
	// Checking and reference model
	// ****
	task chk(input logic [47:0] got, input logic [47:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	function longint coef(input logic [4:0] c);
		return longint'($rtoi($pow(10.0, (-42.0 + 1.5 * c) / 20.0) * 16384.0 + 0.5));
	endfunction
	function logic [23:0] mix(input int b);
		longint acc;
		acc = 0;
		for (int i = 0; i < 7; i++)
			if (md[b][i])
				acc += longint'($signed(src[i])) * coef(md[b + 1 + i][4:0]);
		acc = acc >>> 14;
		return acc > 8388607 ? 24'h7FFFFF : acc < -8388608 ? 24'h800000 : acc[23:0];
	endfunction
	// ****
	// Drivers
	// ****
	// Lowering valid here keeps a held frame from being taken twice during register traffic.
	task wr(input logic [7:0] a, input logic [7:0] d);
		sample_valid = 0;
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr_en = 1;
		@(negedge clk);
		reg_wr_en = 0;
		if (a >= 8'h7C && a <= 8'h8B)
			md[a - 8'h7C] = d & ((a == 8'h7C || a == 8'h84) ? 8'h7F : 8'h1F);
	endtask
	task rd(input logic [7:0] a);
		@(negedge clk);
		reg_addr = a;
		reg_rd_en = 1;
		@(negedge clk);
		reg_rd_en = 0;
		chk({40'h0, reg_rdata}, {40'h0, (a >= 8'h7C && a <= 8'h8B) ? md[a - 8'h7C] : 8'h00});
	endtask
	task send(input int fix);
		int n;
		for (int i = 0; i < 7; i++)
			src[i] = fix == 1 ? 24'h7FFFFF : fix == 2 ? 24'h800000 : 24'($urandom);
		sample_valid = 1;
		n = 0;
		while (sample_ready !== 1'b1 && n < 50)
		begin
			@(negedge clk);
			n++;
		end
		if (sample_ready !== 1'b1)
		begin
			err_total++;
			finish_test;
		end
		exq.push_back({mix(0), mix(8)});
		@(negedge clk);
	endtask
	task drain;
		int n;
		sample_valid = 0;
		n = 0;
		while (exq.size() != 0 && n < 2000)
		begin
			@(negedge clk);
			n++;
		end
		if (exq.size() != 0)
		begin
			err_total++;
			finish_test;
		end
	endtask
	always @(posedge clk)
		if (out_valid === 1'b1 && out_ready === 1'b1)
			chk({lo, ro}, exq.size() != 0 ? exq.pop_front() : 48'hX);
	// ****
	// Scenarios
	// ****
	initial
	begin
		void'($urandom(39));
		repeat (6) @(negedge clk);
		rst_n = 1;
		foreach (md[i])
			md[i] = i == 0 ? 8'h04 : i == 8 ? 8'h08 : 8'h1C;
		for (int a = 'h7A; a <= 'h8D; a++)
			rd(8'(a));
		$display("reset values done");
		for (int a = 'h7B; a <= 'h8C; a++)
		begin
			wr(8'(a), 8'hFF);
			rd(8'(a));
		end
		$display("reserved bits done");
		for (int i = 0; i < 7; i++)
		begin
			wr(8'h7C, 8'h01 << i);
			wr(8'h84, 8'h40 >> i);
			send(0);
		end
		drain;
		$display("single sources done");
		mode <= 2'h1;
		foreach (md[c])
		begin
			for (int a = 1; a < 16; a++)
				if (a != 8)
					wr(8'h7C + 8'(a), c < 4 ? 8'(c) : c < 8 ? 8'h1C : 8'h1F - 8'(c % 4));
			send(0);
		end
		repeat (40)
		begin
			wr(8'h7C + 8'($urandom % 16), 8'($urandom));
			repeat (3) send(0);
		end
		wr(8'h7C, 8'h7F);
		wr(8'h84, 8'h7F);
		send(1);
		send(2);
		drain;
		$display("random mixing done");
		mode <= 2'h2;
		repeat (5) send(0);
		sample_valid = 0;
		@(negedge clk);
		chk({47'h0, sample_ready}, 48'h0);
		mode <= 2'h0;
		drain;
		$display("full buffer done");
		finish_test;
	end
endmodule // dmx_mixer_tb
